// >>> hdl/tsw_pkg.sv
// package of constants and types for the time-slot switch control block
// Notes on behaviour
// (R1) High address line low selects the mode register, other lines ignored.
// (R2) High address line high: five low lines pick channel 0-31 of window.
// (R3) Split bit set: window reads hit data memory, writes hit low connection memory.
// (R4) Split clear: memory-select field picks memory; stream field picks subsection.
// (R5) Select 01 data (read only), 10 low, 11 high; 00 must not be used.
// (R6) Three-bit stream field, unsigned, picks the exposed stream subsection.
// (R7) Message-mode bit set: all channels send low byte, as if bits 2,0 set.
// (R8) Channel message bit set: send that channel's low connection byte directly.
// (R9) Channel message bit clear: low byte addresses data memory; send stored input byte.
// (R10) Drive gate input low: every serial output is high impedance.
// (R11) Drive gate high and message-mode bit set: all outputs driven.
// (R12) Drive gate high, message-mode clear: channel enable bit gates its driver.
// (R13) Each high bit 1 goes out on control output one channel early.
// (R14) Within a channel time, control bits for streams 0 to 7 go in order.
// (R15) High connection bits 7 to 3 read back as zero.
// (R16) Streams run at 2048 kbit/s, 125 us frames, 32 eight-bit channels.
// (R17) Received bytes go to a 256 by 8 data memory, one per stream/channel.
// (R18) Message channels resend the same low byte each frame until rewritten.
// (R19) Mode register writes are fast; memory window accesses acknowledge later.
// (R20) Switched low byte: upper three bits stream, lower five bits channel.
package tsw_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // frame geometry
  localparam int STREAMS       = 8;
  localparam int CHANNELS      = 32;
  localparam int CHAN_BITS     = 8;
  localparam int FRAME_US      = 125;
  localparam int BIT_RATE_KBPS = 2048;

  ////////////////////////////////////////////////////////////////////////////////
  // mode register layout
  localparam int          MODE_SPLIT_BIT = 7;
  localparam int          MODE_MSG_BIT   = 6;
  localparam int          MODE_SEL_HI    = 4;
  localparam int          MODE_SEL_LO    = 3;
  localparam int          MODE_STR_HI    = 2;
  localparam int          MODE_STR_LO    = 0;
  localparam logic [7:0]  MODE_RESET     = 8'h00;
  localparam logic [1:0]  SEL_NONE       = 2'h0;
  localparam logic [1:0]  SEL_DATA       = 2'h1;
  localparam logic [1:0]  SEL_CLOW       = 2'h2;
  localparam logic [1:0]  SEL_CHIGH      = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // connection high layout
  localparam int          HIGH_W      = 3;
  localparam int          HIGH_MSG    = 2;
  localparam int          HIGH_CST    = 1;
  localparam int          HIGH_OE     = 0;
  localparam logic [4:0]  HIGH_UNUSED = 5'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // bus timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int MEM_ACK_NS    = 400;
  localparam int MEM_ACK_CYC   = (MEM_ACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // one received byte with its data memory location
  typedef struct packed {
    logic [2:0] stream;
    logic [4:0] chan;
    logic [7:0] data;
  } tsw_rx_word_type;

  // processor access sequencer
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WAIT = 2'b01,
    BUS_ACK  = 2'b10
  } tsw_bus_state_type;

endpackage

// >>> hdl/tsw_pair_buf.sv
// small valid/ready buffer, two entries by default
module tsw_pair_buf
  import tsw_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [CW-1:0]    count_r;
  logic             push;
  logic             pop;

  // honest full and empty
  assign in_ready  = (count_r != CW'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = store[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // entry storage
  always_ff @(posedge sys_clk) begin
    if (clk_en && push) begin
      store[wr_ptr_r] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (clk_en) begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

// >>> hdl/tsw_switch_ctrl.sv
// time-slot switch: processor window, connection memories and serial streams
module tsw_switch_ctrl
  import tsw_pkg::*;
(
  // clock, reset, enable
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  // processor bus pins
  input  wire logic       bus_cs_n,
  input  wire logic       bus_ds_n,
  input  wire logic       bus_rw,
  input  wire logic       high_address_line,
  input  wire logic [4:0] channel_address_lines,
  input  wire logic [7:0] bus_data_in,
  output logic      [7:0] bus_data_out,
  output logic            bus_data_oe,
  output logic            bus_ack_n_out,
  output logic            bus_ack_oe,
  // serial frame timing
  input  wire logic       bit_clk_in,
  input  wire logic       frame_n_in,
  // serial streams
  input  wire logic [7:0] serial_input_streams,
  input  wire logic       serial_output_drive_gate,
  output logic      [7:0] serial_output_streams,
  output logic      [7:0] serial_output_oe,
  output logic            control_bit_serial_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam int          SYNC_W     = 28;
  localparam logic [27:0] SYNC_RESET = 28'hFFFFFFF;

  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic              cs_n_s;
  logic              ds_n_s;
  logic              rw_s;
  logic              a5_s;
  logic [4:0]        alo_s;
  logic [7:0]        din_s;
  logic              bclk_s;
  logic              frame_n_s;
  logic [7:0]        sti_s;
  logic              gate_s;

  // two flops on every pin
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= SYNC_RESET;
      sync2_r <= SYNC_RESET;
    end else if (clk_en) begin
      sync1_r <= {bus_cs_n, bus_ds_n, bus_rw, high_address_line, channel_address_lines,
                  bus_data_in, bit_clk_in, frame_n_in, serial_input_streams,
                  serial_output_drive_gate};
      sync2_r <= sync1_r;
    end
  end

  assign {cs_n_s, ds_n_s, rw_s, a5_s, alo_s, din_s, bclk_s, frame_n_s, sti_s, gate_s} = sync2_r;

  ////////////////////////////////////////////////////////////////////////////////
  // memories and mode register
  logic [7:0]        data_mem  [256];
  logic [7:0]        conn_low  [256];
  logic [HIGH_W-1:0] conn_high [256];
  logic [7:0]        mode_r;

  // memory targeted by a window access
  function automatic logic [1:0] window_target(input logic [7:0] mode, input logic rd);
    if (mode[MODE_SPLIT_BIT]) begin
      window_target = rd ? SEL_DATA : SEL_CLOW; // [R3]
    end else begin
      window_target = mode[MODE_SEL_HI:MODE_SEL_LO]; // [R4] [R5]
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // frame position
  logic       bclk_d_r;
  logic       bit_edge;
  logic [7:0] pos_r;
  logic [7:0] pos_nxt;
  logic [2:0] bit_nxt;
  logic [4:0] chan_nxt;

  assign bit_edge = bclk_s & ~bclk_d_r;
  // frame pulse low at an edge starts bit 0 of channel 0
  assign pos_nxt  = frame_n_s ? pos_r + 8'h01 : 8'h00; // [R16]
  assign bit_nxt  = pos_nxt[2:0];
  assign chan_nxt = pos_nxt[7:3];

  // bit counter across 32 channels of 8 bits
  // delayed bit clock resets high like its synchroniser, so no false edge after reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bclk_d_r <= 1'b1;
      pos_r    <= 8'hFF;
    end else if (clk_en) begin
      bclk_d_r <= bclk_s;
      if (bit_edge) begin
        pos_r <= pos_nxt; // [R16]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive: deserialise and hand bytes to the buffer one stream at a time
  logic [7:0]      rx_sh_r   [STREAMS];
  logic [7:0]      rx_hold_r [STREAMS];
  logic [4:0]      rx_chan_r;
  logic [2:0]      push_idx_r;
  logic            push_act_r;
  tsw_rx_word_type push_word;
  tsw_rx_word_type drain_word;
  logic            push_ready;
  logic            drain_valid;
  logic            drain_ready;

  // shift in msb first and latch completed bytes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < STREAMS; s++) begin
        rx_sh_r[s]   <= 8'h00;
        rx_hold_r[s] <= 8'h00;
      end
      rx_chan_r <= 5'h00;
    end else if (clk_en && bit_edge) begin
      for (int s = 0; s < STREAMS; s++) begin
        rx_sh_r[s] <= {rx_sh_r[s][6:0], sti_s[s]};
        if (bit_nxt == 3'h7) begin
          rx_hold_r[s] <= {rx_sh_r[s][6:0], sti_s[s]}; // [R17]
        end
      end
      if (bit_nxt == 3'h7) begin
        rx_chan_r <= chan_nxt;
      end
    end
  end

  // walk streams 0..7 into the buffer, stalling on back-pressure
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      push_idx_r <= 3'h0;
      push_act_r <= 1'b0;
    end else if (clk_en) begin
      if (bit_edge && bit_nxt == 3'h7) begin
        push_idx_r <= 3'h0;
        push_act_r <= 1'b1;
      end else if (push_act_r && push_ready) begin
        push_idx_r <= push_idx_r + 3'h1;
        push_act_r <= (push_idx_r != 3'h7);
      end
    end
  end

  assign push_word.stream = push_idx_r;
  assign push_word.chan   = rx_chan_r;
  assign push_word.data   = rx_hold_r[push_idx_r];

  tsw_pair_buf #(
    .WIDTH ($bits(tsw_rx_word_type)),
    .DEPTH (2)
  ) u_rx_buf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .in_valid  (push_act_r),
    .in_ready  (push_ready),
    .in_data   (push_word),
    .out_valid (drain_valid),
    .out_ready (drain_ready),
    .out_data  (drain_word)
  );

  // data memory write, one location per stream and channel
  always_ff @(posedge sys_clk) begin
    if (clk_en && drain_valid && drain_ready) begin
      data_mem[{drain_word.stream, drain_word.chan}] <= drain_word.data; // [R17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transmit: fetch stream b of the next channel during bit b
  logic [7:0]        tx_sh_r   [STREAMS];
  logic [7:0]        tx_next_r [STREAMS];
  logic [7:0]        tx_en_r;
  logic [7:0]        en_next_r;
  logic [7:0]        fetch_addr;
  logic [7:0]        fetch_low;
  logic [HIGH_W-1:0] fetch_high;
  logic              fetch_msg;
  logic              fetch_en;

  assign fetch_addr = {bit_nxt, chan_nxt + 5'h01}; // [R13] [R14]
  assign fetch_low  = conn_low[fetch_addr];
  assign fetch_high = conn_high[fetch_addr];
  assign fetch_msg  = mode_r[MODE_MSG_BIT] | fetch_high[HIGH_MSG]; // [R7] [R8]
  assign fetch_en   = mode_r[MODE_MSG_BIT] | fetch_high[HIGH_OE]; // [R11] [R12]

  // next-channel bytes, enables and early control bit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < STREAMS; s++) begin
        tx_next_r[s] <= 8'h00;
      end
      en_next_r              <= 8'h00;
      control_bit_serial_out <= 1'b0;
    end else if (clk_en && bit_edge) begin
      // switched byte: low byte is {stream, channel} into data memory
      tx_next_r[bit_nxt]     <= fetch_msg ? fetch_low : data_mem[fetch_low]; // [R9] [R20] [R18]
      en_next_r[bit_nxt]     <= fetch_en;
      control_bit_serial_out <= fetch_high[HIGH_CST]; // [R13] [R14]
    end
  end

  // load at channel start, then shift msb first
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < STREAMS; s++) begin
        tx_sh_r[s] <= 8'h00;
      end
      tx_en_r <= 8'h00;
    end else if (clk_en && bit_edge) begin
      for (int s = 0; s < STREAMS; s++) begin
        tx_sh_r[s] <= (bit_nxt == 3'h0) ? tx_next_r[s] : {tx_sh_r[s][6:0], 1'b0};
      end
      if (bit_nxt == 3'h0) begin
        tx_en_r <= en_next_r;
      end
    end
  end

  // output pins and drivers
  always_comb begin
    for (int s = 0; s < STREAMS; s++) begin
      serial_output_streams[s] = tx_sh_r[s][7];
    end
  end
  assign serial_output_oe = {STREAMS{gate_s}} & tx_en_r; // [R10] [R11] [R12]

  ////////////////////////////////////////////////////////////////////////////////
  // processor access sequencer
  tsw_bus_state_type bus_state_r;
  logic [2:0]        wait_cnt_r;
  logic [7:0]        acc_addr_r;
  logic              acc_rd_r;
  logic [7:0]        acc_din_r;
  logic [7:0]        rd_data_r;
  logic [1:0]        acc_target;
  logic              bus_req;
  logic              mem_do;

  assign bus_req    = ~cs_n_s & ~ds_n_s;
  assign acc_target = window_target(mode_r, acc_rd_r);
  assign mem_do     = (bus_state_r == BUS_WAIT) && (wait_cnt_r == 3'h0);
  // hold data memory writes while the processor reads it
  assign drain_ready = !((bus_state_r == BUS_WAIT) && acc_rd_r && acc_target == SEL_DATA);

  // request capture, wait and acknowledge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_state_r <= BUS_IDLE;
      wait_cnt_r  <= 3'h0;
      acc_addr_r  <= 8'h00;
      acc_rd_r    <= 1'b0;
      acc_din_r   <= 8'h00;
      rd_data_r   <= 8'h00;
      mode_r      <= MODE_RESET;
    end else if (clk_en) begin
      unique case (bus_state_r)
        BUS_IDLE: begin
          if (bus_req) begin
            // window offset from stream field plus channel lines
            acc_addr_r <= {mode_r[MODE_STR_HI:MODE_STR_LO], alo_s}; // [R2] [R6]
            acc_rd_r   <= rw_s;
            acc_din_r  <= din_s;
            if (!a5_s && !rw_s) begin
              mode_r      <= din_s; // [R1] [R19]
              bus_state_r <= BUS_ACK;
            end else begin
              wait_cnt_r  <= 3'(MEM_ACK_CYC - 1); // [R19]
              bus_state_r <= BUS_WAIT;
            end
            if (!a5_s && rw_s) begin
              acc_addr_r[7] <= 1'b0;
            end
          end
        end
        BUS_WAIT: begin
          if (wait_cnt_r != 3'h0) begin
            wait_cnt_r <= wait_cnt_r - 3'h1;
          end else begin
            bus_state_r <= BUS_ACK;
            if (acc_rd_r) begin
              if (!a5_s) begin
                rd_data_r <= mode_r; // [R1]
              end else begin
                unique case (acc_target)
                  SEL_DATA:  rd_data_r <= data_mem[acc_addr_r];
                  SEL_CLOW:  rd_data_r <= conn_low[acc_addr_r];
                  SEL_CHIGH: rd_data_r <= {HIGH_UNUSED, conn_high[acc_addr_r]}; // [R15]
                  SEL_NONE:  rd_data_r <= 8'h00; // [R5]
                endcase
              end
            end
          end
        end
        BUS_ACK: begin
          if (!bus_req) begin
            bus_state_r <= BUS_IDLE;
          end
        end
        default: bus_state_r <= BUS_IDLE;
      endcase
    end
  end

  // connection memory writes; data memory is read only from the bus
  always_ff @(posedge sys_clk) begin
    if (clk_en && mem_do && !acc_rd_r && a5_s) begin
      if (acc_target == SEL_CLOW) begin
        conn_low[acc_addr_r] <= acc_din_r; // [R3] [R4] [R18]
      end
      if (acc_target == SEL_CHIGH) begin
        conn_high[acc_addr_r] <= acc_din_r[HIGH_W-1:0]; // [R15]
      end
    end
  end

  // open-drain acknowledge and read data drive
  assign bus_ack_n_out = 1'b0;
  assign bus_ack_oe    = (bus_state_r == BUS_ACK);
  assign bus_data_oe   = (bus_state_r == BUS_ACK) & acc_rd_r & bus_req;
  assign bus_data_out  = rd_data_r;

endmodule

// >>> verification/tsw_switch_ctrl_assertions.sv
// port-level checker for the time-slot switch control block
module tsw_switch_ctrl_chk
  import tsw_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // processor bus
  input wire logic       bus_cs_n,
  input wire logic       bus_ds_n,
  input wire logic       bus_rw,
  input wire logic       high_address_line,
  input wire logic       bus_data_oe,
  input wire logic       bus_ack_n_out,
  input wire logic       bus_ack_oe,
  // serial side
  input wire logic       bit_clk_in,
  input wire logic       serial_output_drive_gate,
  input wire logic [7:0] serial_output_streams,
  input wire logic [7:0] serial_output_oe,
  input wire logic       control_bit_serial_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // processor handshake
  mode_fast_a: assert property ($fell(bus_ds_n) && !bus_cs_n && !bus_rw && !high_address_line
    |-> ##[1:5] bus_ack_oe) else $error("mode write not acknowledged fast");
  window_slow_a: assert property ($fell(bus_ds_n) && !bus_cs_n && (bus_rw || high_address_line)
    |-> !bus_ack_oe [*5] ##[1:10] bus_ack_oe) else $error("slow access ack timing wrong");
  ack_rise_a: assert property ($rose(bus_ack_oe) |-> !$past(bus_ds_n) && !$past(bus_cs_n))
    else $error("ack without strobe");
  ack_fall_a: assert property ($fell(bus_ack_oe) |-> $past(bus_ds_n || bus_cs_n))
    else $error("ack dropped while strobe held");
  read_drive_a: assert property (bus_data_oe |-> bus_ack_oe && bus_rw)
    else $error("data driven outside a read ack");
  ack_hold_a: assert property (bus_ack_oe && !bus_ds_n && !bus_cs_n
    |=> bus_ack_oe && bus_ack_n_out == 1'h0) else $error("ack dropped with strobe held");

  ////////////////////////////////////////////////////////////////////////////////
  // serial drivers and timing
  gate_off_a: assert property (!serial_output_drive_gate [*4] |=> serial_output_oe == 8'h00)
    else $error("outputs driven with gate low");
  gate_need_a: assert property (serial_output_oe != 8'h00 |->
    $past(serial_output_drive_gate, 2) || $past(serial_output_drive_gate, 3))
    else $error("driver enabled without gate");
  ctl_edge_a: assert property ($changed(control_bit_serial_out) |-> $past(bit_clk_in, 2)
    || $past(bit_clk_in, 3) || $past(bit_clk_in, 4)) else $error("control bit moved off edge");
  ser_edge_a: assert property ($changed(serial_output_streams) |-> $past(bit_clk_in, 2)
    || $past(bit_clk_in, 3) || $past(bit_clk_in, 4)) else $error("serial bit moved off edge");

  // main scenarios reached
  mode_wr_c: cover property (!bus_rw && !high_address_line && $rose(bus_ack_oe));
  read_c: cover property ($rose(bus_data_oe));
  oe_on_c: cover property (serial_output_oe != 8'h00);
endmodule

bind tsw_switch_ctrl tsw_switch_ctrl_chk u_chk (
  .sys_clk(sys_clk), .rst(rst), .bus_cs_n(bus_cs_n), .bus_ds_n(bus_ds_n), .bus_rw(bus_rw),
  .high_address_line(high_address_line), .bus_data_oe(bus_data_oe),
  .bus_ack_n_out(bus_ack_n_out), .bus_ack_oe(bus_ack_oe), .bit_clk_in(bit_clk_in),
  .serial_output_drive_gate(serial_output_drive_gate),
  .serial_output_streams(serial_output_streams), .serial_output_oe(serial_output_oe),
  .control_bit_serial_out(control_bit_serial_out));

// >>> verification/tsw_cpu_model.sv
// processor bus model driving the switch control pins
module tsw_cpu_model
  import tsw_pkg::*;
(
  // clock
  input  wire logic       sys_clk,
  // pins toward the device
  output logic            bus_cs_n,
  output logic            bus_ds_n,
  output logic            bus_rw,
  output logic            high_address_line,
  output logic      [4:0] channel_address_lines,
  output logic      [7:0] bus_data_in,
  // answer from the device
  input  wire logic [7:0] bus_data_out,
  input  wire logic       bus_data_oe,
  input  wire logic       bus_ack_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus at time zero
  initial begin
    bus_cs_n = 1'h1;
    bus_ds_n = 1'h1;
    bus_rw = 1'h1;
    high_address_line = 1'h0;
    channel_address_lines = 5'h00;
    bus_data_in = 8'h00;
  end

  // one access: hold until ack, take data, release, wait for ack to drop
  task automatic acc(input logic r, input logic a, input logic [4:0] c, input logic [7:0] w,
                     output logic [7:0] q, output logic ok);
    int n;
    @(posedge sys_clk);
    bus_cs_n <= 1'h0;
    bus_ds_n <= 1'h0;
    bus_rw <= r;
    high_address_line <= a;
    channel_address_lines <= c;
    bus_data_in <= w;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (bus_ack_oe !== 1'h1 && n < 40);
    ok = (bus_ack_oe === 1'h1) && (!r || bus_data_oe === 1'h1);
    q = bus_data_out;
    bus_cs_n <= 1'h1;
    bus_ds_n <= 1'h1;
    channel_address_lines <= ~c; // released lines do not keep the value
    bus_data_in <= ~w;
    n = 0;
    while (bus_ack_oe !== 1'h0 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    ok = ok && (bus_ack_oe === 1'h0);
  endtask
endmodule

// >>> verification/tsw_switch_ctrl_bench.sv
// self-checking bench for the time-slot switch control block
module tsw_switch_ctrl_bench;
  import tsw_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic       sys_clk = 1'h0;
  logic       rst     = 1'h1;
  logic       bclk    = 1'h0;
  logic       frm_n   = 1'h1;
  logic       gate    = 1'h0;
  logic [7:0] sin     = 8'h00;
  logic [2:0] cnt     = 3'h0;
  logic       cs_n, ds_n, rw, a5, d_oe, ack_n, ack_oe, cst_o;
  logic [4:0] ch;
  logic [7:0] d_in, d_out, so, so_oe;
  logic [7:0] cap [8][32];
  logic       cap_oe [8][32];
  logic       cst [256];
  int         bpos = 0;
  int         frames = 0;
  int         err_total = 0;
  int         n_compared = 0;

  tsw_cpu_model u_cpu (.sys_clk(sys_clk), .bus_cs_n(cs_n), .bus_ds_n(ds_n), .bus_rw(rw),
    .high_address_line(a5), .channel_address_lines(ch), .bus_data_in(d_in),
    .bus_data_out(d_out), .bus_data_oe(d_oe), .bus_ack_oe(ack_oe));

  tsw_switch_ctrl dut (.sys_clk(sys_clk), .rst(rst), .clk_en(1'h1), .bus_cs_n(cs_n),
    .bus_ds_n(ds_n), .bus_rw(rw), .high_address_line(a5), .channel_address_lines(ch),
    .bus_data_in(d_in), .bus_data_out(d_out), .bus_data_oe(d_oe), .bus_ack_n_out(ack_n),
    .bus_ack_oe(ack_oe), .bit_clk_in(bclk), .frame_n_in(frm_n), .serial_input_streams(sin),
    .serial_output_drive_gate(gate), .serial_output_streams(so), .serial_output_oe(so_oe),
    .control_bit_serial_out(cst_o));

  // 100 ns system clock
  initial forever #50 sys_clk = ~sys_clk;

  // input byte of a stream and channel
  function automatic logic [7:0] pat(int s, int c);
    return {s[2:0], c[4:0]} ^ 8'h5A;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // bit clock of eight system clocks, frame pulse, inputs and output capture
  always @(posedge sys_clk) begin
    int q;
    logic [7:0] v;
    cnt <= cnt + 3'h1;
    if (cnt == 3'h4) begin
      bclk <= 1'h0;
      frm_n <= (bpos != 0);
      for (int s = 0; s < 8; s++) begin
        v = pat(s, bpos / 8);
        sin[s] <= v[7 - bpos % 8];
      end
    end
    if (cnt == 3'h0) begin
      bclk <= 1'h1;
      q = (bpos + 255) % 256;
      for (int s = 0; s < 8; s++) begin
        cap[s][q / 8][7 - q % 8] = so[s];
        cap_oe[s][q / 8] = so_oe[s];
      end
      cst[q] = cst_o;
      if (bpos == 0) frames++;
      bpos = (bpos + 1) % 256;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic acc(logic r, logic a, logic [4:0] c, logic [7:0] w, output logic [7:0] q);
    logic ok;
    u_cpu.acc(r, a, c, w, q, ok);
    if (!ok) begin
      err_total++;
      $display("ERROR bus_ack expected 1 seen 0");
      results();
    end
  endtask

  task automatic wr(logic a, logic [4:0] c, logic [7:0] w);
    logic [7:0] q;
    acc(1'h0, a, c, w, q);
  endtask

  task automatic rd(string nm, logic a, logic [4:0] c, logic [7:0] e);
    logic [7:0] q;
    acc(1'h1, a, c, 8'h00, q);
    chk(nm, e, q);
  endtask

  task automatic wait_frames(int n);
    int t;
    t = frames + n;
    for (int i = 0; i < n * 2200 && frames < t; i++) @(posedge sys_clk);
    if (frames < t) begin
      err_total++;
      $display("ERROR frame_count expected %0d seen %0d", t, frames);
      results();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'h0;
    repeat (4) @(posedge sys_clk);
    rd("mode_reset", 1'h0, 5'h00, 8'h00);
    wr(1'h0, 5'h1F, 8'h17);
    rd("mode", 1'h0, 5'h0A, 8'h17);
    wr(1'h1, 5'h1F, 8'hA5);
    wr(1'h0, 5'h00, 8'h13);
    wr(1'h1, 5'h1F, 8'h5A);
    wr(1'h0, 5'h00, 8'h17);
    rd("low_s7", 1'h1, 5'h1F, 8'hA5);
    wr(1'h0, 5'h00, 8'h1B);
    wr(1'h1, 5'h00, 8'hFF);
    rd("high_rd", 1'h1, 5'h00, 8'h07);
    wait_frames(2);
    wr(1'h0, 5'h00, 8'h0C);
    rd("data_mem", 1'h1, 5'h09, pat(4, 9));
    wr(1'h1, 5'h09, 8'h00);
    rd("data_ro", 1'h1, 5'h09, pat(4, 9));
    wr(1'h0, 5'h00, 8'h82);
    wr(1'h1, 5'h05, 8'hC3);
    rd("split_rd", 1'h1, 5'h05, pat(2, 5));
    wr(1'h0, 5'h00, 8'h12);
    rd("split_wr", 1'h1, 5'h05, 8'hC3);
    wr(1'h1, 5'h06, 8'h89);
    wr(1'h1, 5'h07, 8'h3C);
    wr(1'h0, 5'h00, 8'h1A);
    wr(1'h1, 5'h05, 8'h05);
    wr(1'h1, 5'h06, 8'h03);
    wr(1'h1, 5'h07, 8'h04);
    gate <= 1'h1;
    wait_frames(2);
    for (int k = 0; k < 2; k++) begin
      chk("msg_byte", 8'hC3, cap[2][5]);
      wait_frames(1);
    end
    chk("msg_oe", 8'h01, {7'h00, cap_oe[2][5]});
    chk("switched", pat(4, 9), cap[2][6]);
    chk("oe_off", 8'h00, {7'h00, cap_oe[2][7]});
    chk("ctl_set", 8'h01, {7'h00, cst[42]});
    chk("ctl_clear", 8'h00, {7'h00, cst[34]});
    gate <= 1'h0;
    wait_frames(2);
    chk("gate_low", 8'h00, {7'h00, cap_oe[2][5]});
    gate <= 1'h1;
    wr(1'h0, 5'h00, 8'h52);
    wait_frames(2);
    chk("all_msg7", 8'h3C, cap[2][7]);
    chk("all_msg6", 8'h89, cap[2][6]);
    chk("all_oe", 8'h01, {7'h00, cap_oe[2][7]});
    results();
  end
endmodule
